/* File: ppm_params.svh */
// Constants, register map and field layout for the parallel port strap mux
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH

`define PPM_HALF_W       16
`define PPM_ADDR_W       12
// Register byte offsets
`define PPM_OFS_BUSCTL   12'h000
`define PPM_OFS_STATUS   12'h004
`define PPM_OFS_PIO_OUT  12'h008
`define PPM_OFS_PIO_DIR  12'h00c
`define PPM_OFS_PIO_IN   12'h010
`define PPM_OFS_MEM_ADDR 12'h014
`define PPM_OFS_MEM_DATA 12'h018
// Bus control fields: holder enables
`define PPM_BIT_HOLD_ADDR 0
`define PPM_BIT_HOLD_DLO  1
`define PPM_BIT_HOLD_DHI  2
`define PPM_BUSCTL_RST    3'h7
// Memory data control: bit 16 define is unused; a MEM_DATA write drives data onto the bus in memory mode only
`define PPM_BIT_MEM_DRIVE 16
`define PPM_ZERO16        16'h0000
`define PPM_ZERO32        32'h0000_0000

`endif

/* File: ppm_pkg.sv */
// Types shared by the parallel port strap mux
package ppm_pkg;
	typedef enum logic [1:0] {
		PPM_ST_RESET,
		PPM_ST_HOST,
		PPM_ST_MEM
	} ppm_mode_t;
endpackage : ppm_pkg

/* File: ppm_bus_holder.sv */
// Bus holder model for one group of pins
`timescale 1ns/1ps
`include "ppm_params.svh"
module ppm_bus_holder
	import ppm_pkg::*;
#(
	parameter int W = `PPM_HALF_W
)
(
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	// Pin side
	input  wire logic [W-1:0] pin_in,
	input  wire logic [W-1:0] pin_oe,
	input  wire logic         hold_en,
	// Held level and its enable
	output logic      [W-1:0] hold_val,
	output logic      [W-1:0] hold_oe
);
	typedef struct packed {
		logic [W-1:0] last;
	} ppm_hold_state_t;

	ppm_hold_state_t s_q;
	ppm_hold_state_t s_d;

	// Follows the wire whoever drives it, device or far side, so a released
	// line keeps the level that was last driven onto it
	always_comb
	begin
		s_d      = s_q;
		s_d.last = pin_in;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign hold_val = s_q.last;
	assign hold_oe  = hold_en ? ~pin_oe : '0;
endmodule : ppm_bus_holder

/* File: ppm_strap_mux.sv */
// Parallel port function select from a reset-time strap, with APB registers
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "ppm_params.svh"
module ppm_strap_mux
	import ppm_pkg::*;
#(
	parameter int HW = `PPM_HALF_W
)
(
	// Clock and reset
	input  wire logic            sys_clk,
	input  wire logic            rst_n,
	// Strap
	input  wire logic            mode_strap_pin,
	// APB slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [11:0]     paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	// Address pins A[17:2]
	input  wire logic [HW-1:0]   addr_pin_i,
	output logic      [HW-1:0]   addr_pin_o,
	output logic      [HW-1:0]   addr_pin_oe,
	// Data pins D[31:16]
	input  wire logic [HW-1:0]   dhi_pin_i,
	output logic      [HW-1:0]   dhi_pin_o,
	output logic      [HW-1:0]   dhi_pin_oe,
	// Data pins D[15:0]
	input  wire logic [HW-1:0]   dlo_pin_i,
	output logic      [HW-1:0]   dlo_pin_o,
	output logic      [HW-1:0]   dlo_pin_oe,
	// Host port side
	output logic      [HW-1:0]   host_port_address_bus,
	output logic      [HW-1:0]   host_port_data_bus,
	input  wire logic [HW-1:0]   host_port_rd_data,
	input  wire logic            host_port_rd_en,
	output logic                 host_port_sel,
	output logic                 ext_mem_sel
);
	typedef struct packed {
		ppm_mode_t        mode;
		logic             strap;
		logic [2:0]       busctl;
		logic [HW-1:0]    pio_out;
		logic [HW-1:0]    pio_dir;
		logic [HW-1:0]    mem_addr;
		logic [2*HW-1:0]  mem_data;
		logic             mem_drive;
		logic [31:0]      rdata;
	} ppm_state_t;

	ppm_state_t s_q;
	ppm_state_t s_d;

	logic          acc;
	logic          wr_acc;
	logic          rd_acc;
	logic          hit;
	logic          is_host;
	logic          is_mem;
	logic [HW-1:0] a_oe_fn;
	logic [HW-1:0] a_o_fn;
	logic [HW-1:0] hi_oe_fn;
	logic [HW-1:0] hi_o_fn;
	logic [HW-1:0] lo_oe_fn;
	logic [HW-1:0] lo_o_fn;
	logic [HW-1:0] a_hv;
	logic [HW-1:0] a_hoe;
	logic [HW-1:0] hi_hv;
	logic [HW-1:0] hi_hoe;
	logic [HW-1:0] lo_hv;
	logic [HW-1:0] lo_hoe;

	assign acc     = psel && penable;
	assign wr_acc  = acc && pwrite;
	assign rd_acc  = acc && !pwrite;
	assign is_host = (s_q.mode == PPM_ST_HOST);
	assign is_mem  = (s_q.mode == PPM_ST_MEM);

	always_comb
	begin
		unique case (paddr)
			`PPM_OFS_BUSCTL, `PPM_OFS_STATUS, `PPM_OFS_PIO_OUT, `PPM_OFS_PIO_DIR,
			`PPM_OFS_PIO_IN, `PPM_OFS_MEM_ADDR, `PPM_OFS_MEM_DATA: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// -------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		// Strap is tracked only while reset is held; first edge out fixes mode
		if (s_q.mode == PPM_ST_RESET)
			s_d.mode = s_q.strap ? PPM_ST_MEM : PPM_ST_HOST;
		if (wr_acc)
		begin
			unique case (paddr)
				`PPM_OFS_BUSCTL:   s_d.busctl = pwdata[2:0];
				`PPM_OFS_PIO_OUT:  s_d.pio_out = pwdata[HW-1:0];
				`PPM_OFS_PIO_DIR:  s_d.pio_dir = pwdata[HW-1:0];
				`PPM_OFS_MEM_ADDR: s_d.mem_addr = pwdata[HW-1:0];
				`PPM_OFS_MEM_DATA:
				begin
					s_d.mem_data  = pwdata;
					s_d.mem_drive = 1'b1;
				end
				default: ;
			endcase
		end
		// A memory read releases the data bus so the device can answer
		if (rd_acc && paddr == `PPM_OFS_MEM_DATA)
			s_d.mem_drive = 1'b0;
		s_d.rdata = `PPM_ZERO32;
		if (psel && !penable && !pwrite)
		begin
			unique case (paddr)
				`PPM_OFS_BUSCTL:   s_d.rdata = {29'h0, s_q.busctl};
				`PPM_OFS_STATUS:   s_d.rdata = {30'h0, is_mem, is_host};
				`PPM_OFS_PIO_OUT:  s_d.rdata = {16'h0, s_q.pio_out};
				`PPM_OFS_PIO_DIR:  s_d.rdata = {16'h0, s_q.pio_dir};
				`PPM_OFS_PIO_IN:   s_d.rdata = {16'h0, dhi_pin_i};
				`PPM_OFS_MEM_ADDR: s_d.rdata = {16'h0, s_q.mem_addr};
				`PPM_OFS_MEM_DATA: s_d.rdata = {dhi_pin_i, dlo_pin_i};
				default:           s_d.rdata = `PPM_ZERO32;
			endcase
		end
	end

	// Reset values: function drives released, holders on and driving every pin, every direction input
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			s_q.mode      <= PPM_ST_RESET;
			s_q.busctl    <= `PPM_BUSCTL_RST;
			s_q.pio_out   <= `PPM_ZERO16;
			s_q.pio_dir   <= `PPM_ZERO16;
			s_q.mem_addr  <= `PPM_ZERO16;
			s_q.mem_data  <= `PPM_ZERO32;
			s_q.mem_drive <= 1'b0;
			s_q.rdata     <= `PPM_ZERO32;
			s_q.strap     <= mode_strap_pin; // clocked sample, not async
		end
		else
			s_q <= s_d;
	end

	// -------------------------------------------------------------
	// Pin function per mode
	// -------------------------------------------------------------
	always_comb
	begin
		a_oe_fn  = '0;
		a_o_fn   = '0;
		hi_oe_fn = '0;
		hi_o_fn  = '0;
		lo_oe_fn = '0;
		lo_o_fn  = '0;
		if (is_mem)
		begin
			a_oe_fn  = '1;
			a_o_fn   = s_q.mem_addr;
			hi_oe_fn = {HW{s_q.mem_drive}};
			hi_o_fn  = s_q.mem_data[2*HW-1:HW];
			lo_oe_fn = {HW{s_q.mem_drive}};
			lo_o_fn  = s_q.mem_data[HW-1:0];
		end
		else if (is_host)
		begin
			// Host owns D[15:0] direction; device drives its read data word there and pio_out on D[31:16] per pio_dir
			hi_oe_fn = s_q.pio_dir;
			hi_o_fn  = s_q.pio_out;
			lo_oe_fn = {HW{host_port_rd_en}};
			lo_o_fn  = host_port_rd_data;
		end
	end

	ppm_bus_holder #(.W(HW)) u_hold_a (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.pin_in  (addr_pin_i),
		.pin_oe  (a_oe_fn),
		.hold_en (s_q.busctl[`PPM_BIT_HOLD_ADDR]),
		.hold_val(a_hv),
		.hold_oe (a_hoe)
	);
	ppm_bus_holder #(.W(HW)) u_hold_hi (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.pin_in  (dhi_pin_i),
		.pin_oe  (hi_oe_fn),
		.hold_en (s_q.busctl[`PPM_BIT_HOLD_DHI]),
		.hold_val(hi_hv),
		.hold_oe (hi_hoe)
	);
	ppm_bus_holder #(.W(HW)) u_hold_lo (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.pin_in  (dlo_pin_i),
		.pin_oe  (lo_oe_fn),
		.hold_en (s_q.busctl[`PPM_BIT_HOLD_DLO]),
		.hold_val(lo_hv),
		.hold_oe (lo_hoe)
	);

	// Holder drive is weak in silicon; here it simply fills undriven lines
	assign addr_pin_oe = a_oe_fn | a_hoe;
	assign addr_pin_o  = (a_o_fn & a_oe_fn) | (a_hv & ~a_oe_fn);
	assign dhi_pin_oe  = hi_oe_fn | hi_hoe;
	assign dhi_pin_o   = (hi_o_fn & hi_oe_fn) | (hi_hv & ~hi_oe_fn);
	assign dlo_pin_oe  = lo_oe_fn | lo_hoe;
	assign dlo_pin_o   = (lo_o_fn & lo_oe_fn) | (lo_hv & ~lo_oe_fn);

	assign host_port_address_bus = is_host ? addr_pin_i : '0;
	assign host_port_data_bus    = is_host ? dlo_pin_i : '0;
	assign host_port_sel         = is_host;
	assign ext_mem_sel           = is_mem;

	assign pready  = 1'b1;
	assign pslverr = acc && !hit;
	assign prdata  = s_q.rdata;

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	property p_host_addr_in;
		@(posedge sys_clk) disable iff (!rst_n) is_host |-> (a_oe_fn == '0);
	endproperty
	a_host_addr_in: assert property (p_host_addr_in) else $error("host addr driven");

	property p_mem_addr_out;
		@(posedge sys_clk) disable iff (!rst_n)
			$rose(is_mem) |-> (a_oe_fn == '1) && (addr_pin_o == '0);
	endproperty
	a_mem_addr_out: assert property (p_mem_addr_out) else $error("mem addr not 0");

	property p_reset_z;
		@(posedge sys_clk) !rst_n |=> (a_oe_fn == '0) && (hi_oe_fn == '0) && (lo_oe_fn == '0);
	endproperty
	a_reset_z: assert property (p_reset_z) else $error("pins driven in reset");

	property p_mode_fix;
		@(posedge sys_clk) disable iff (!rst_n)
			(s_q.mode == PPM_ST_RESET) |=> (is_mem == s_q.strap) && (is_host == !s_q.strap);
	endproperty
	a_mode_fix: assert property (p_mode_fix) else $error("mode not from strap");

	property p_mode_hold;
		@(posedge sys_clk) disable iff (!rst_n)
			(s_q.mode != PPM_ST_RESET) |=> $stable(s_q.mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed");

	property p_pio_in;
		@(posedge sys_clk) disable iff (!rst_n)
			$rose(is_host) |-> (hi_oe_fn == '0) && (lo_oe_fn == '0 || host_port_rd_en);
	endproperty
	a_pio_in: assert property (p_pio_in) else $error("host data not input");

	property p_mem_data_in;
		@(posedge sys_clk) disable iff (!rst_n)
			$rose(is_mem) |-> (hi_oe_fn == '0) && (lo_oe_fn == '0);
	endproperty
	a_mem_data_in: assert property (p_mem_data_in) else $error("mem data not input");

	property p_holder_rst;
		@(posedge sys_clk) $rose(rst_n) |-> s_q.busctl == `PPM_BUSCTL_RST;
	endproperty
	a_holder_rst: assert property (p_holder_rst) else $error("holders off at reset");

	property p_host_word;
		@(posedge sys_clk) disable iff (!rst_n)
			is_host && host_port_rd_en |-> (dlo_pin_oe == '1) && (dlo_pin_o == host_port_rd_data);
	endproperty
	a_host_word: assert property (p_host_word) else $error("host word wrong");

	property p_host_lo;
		@(posedge sys_clk) disable iff (!rst_n)
			is_host && !host_port_rd_en |-> lo_oe_fn == '0;
	endproperty
	a_host_lo: assert property (p_host_lo) else $error("host data driven");

	property p_hold_keep;
		@(posedge sys_clk) disable iff (!rst_n)
			s_q.busctl[`PPM_BIT_HOLD_DLO] && $fell(lo_oe_fn[0]) |-> dlo_pin_oe[0]
				&& dlo_pin_o[0] == $past(dlo_pin_i[0]);
	endproperty
	a_hold_keep: assert property (p_hold_keep) else $error("holder lost level");

	property p_mem_data_map;
		@(posedge sys_clk) disable iff (!rst_n)
			is_mem && s_q.mem_drive |-> dhi_pin_o == s_q.mem_data[31:16]
				&& dlo_pin_o == s_q.mem_data[15:0];
	endproperty
	a_mem_data_map: assert property (p_mem_data_map) else $error("mem data map");

	c_host: cover property (@(posedge sys_clk) $rose(is_host));
	c_mem: cover property (@(posedge sys_clk) $rose(is_mem));
	c_hold_off: cover property (@(posedge sys_clk) rst_n && s_q.busctl == 3'h0);
	c_mem_wr: cover property (@(posedge sys_clk) is_mem && s_q.mem_drive);
endmodule : ppm_strap_mux

/* File: ppm_far_end.sv */
// Far-side model of one 16-bit pin group: host or memory devices on the wire
`timescale 1ns/1ps
module ppm_far_end
#(
	parameter int W = 16
)
(
	// Clock
	input  wire logic         sys_clk,
	// Device side
	input  wire logic [W-1:0] dut_o,
	input  wire logic [W-1:0] dut_oe,
	// Far side drive
	input  wire logic [W-1:0] ext_oe,
	input  wire logic [W-1:0] ext_val,
	// Resolved wire level
	output logic      [W-1:0] lvl
);
	logic [W-1:0] last_q = '0;

	// --------------------------------------------------------------
	// Wire resolution
	// --------------------------------------------------------------
	// A strong outside driver beats the weak bus holder; an undriven
	// line toggles so that a stale value can never pass for a held one
	always_comb
	begin
		for (int i = 0; i < W; i++)
		begin
			if (ext_oe[i])
				lvl[i] = ext_val[i];
			else if (dut_oe[i])
				lvl[i] = dut_o[i];
			else
				lvl[i] = ~last_q[i];
		end
	end

	always_ff @(posedge sys_clk)
		last_q <= lvl;
endmodule : ppm_far_end

/* File: ppm_strap_mux_tb.sv */
// Self-checking testbench for the strap-selected parallel port mux
`timescale 1ns/1ps
`include "ppm_params.svh"
module ppm_strap_mux_tb;
	logic        sys_clk, rst_n, mode_strap_pin, psel, penable, pwrite, err;
	logic        pready, pslverr, rd_en, hsel, msel;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] a_o, a_oe, a_i, h_o, h_oe, h_i, l_o, l_oe, l_i, hp_a, hp_d, rd_word;
	logic [15:0] xa_oe, xa_v, xh_oe, xh_v, xl_oe, xl_v;
	int          error_cnt, tests_run;

	ppm_strap_mux dut (.sys_clk(sys_clk), .rst_n(rst_n), .mode_strap_pin(mode_strap_pin),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.addr_pin_i(a_i), .addr_pin_o(a_o), .addr_pin_oe(a_oe),
		.dhi_pin_i(h_i), .dhi_pin_o(h_o), .dhi_pin_oe(h_oe),
		.dlo_pin_i(l_i), .dlo_pin_o(l_o), .dlo_pin_oe(l_oe),
		.host_port_address_bus(hp_a), .host_port_data_bus(hp_d),
		.host_port_rd_data(rd_word), .host_port_rd_en(rd_en),
		.host_port_sel(hsel), .ext_mem_sel(msel));
	ppm_far_end far_a (.sys_clk(sys_clk), .dut_o(a_o), .dut_oe(a_oe), .ext_oe(xa_oe),
		.ext_val(xa_v), .lvl(a_i));
	ppm_far_end far_h (.sys_clk(sys_clk), .dut_o(h_o), .dut_oe(h_oe), .ext_oe(xh_oe),
		.ext_val(xh_v), .lvl(h_i));
	ppm_far_end far_l (.sys_clk(sys_clk), .dut_o(l_o), .dut_oe(l_oe), .ext_oe(xl_oe),
		.ext_val(xl_v), .lvl(l_i));

	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	// Waits for pready without assuming the slave's latency
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge sys_clk);
		end
		while (pready !== 1'b1);
		chk("pready", 32'h1, {31'h0, pready});
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb

	// Strap toggles in reset; only its level at the last reset edge counts
	task reset_dut(input logic strap);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		mode_strap_pin <= ~strap;
		repeat (8) @(posedge sys_clk);
		mode_strap_pin <= strap;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : reset_dut

	task ext(input logic [15:0] ao, av, ho, hv, lo, lv);
		@(posedge sys_clk);
		xa_oe <= ao;
		xa_v <= av;
		xh_oe <= ho;
		xh_v <= hv;
		xl_oe <= lo;
		xl_v <= lv;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : ext

	// --------------------------------------------------------------
	// Clock, watchdog and tests
	// --------------------------------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	initial
	begin
		repeat (3000) @(posedge sys_clk);
		error_cnt++;
		tally_and_finish();
	end

	initial
	begin
		{rst_n, mode_strap_pin, psel, penable, pwrite, rd_en} = '0;
		{paddr, pwdata, rd_word, xa_oe, xa_v, xh_oe, xh_v, xl_oe, xl_v} = '0;
		error_cnt = 0;
		tests_run = 0;
		reset_dut(1'b0);
		chk("host_sel", 32'h1, {31'h0, hsel});
		chk("mem_sel", 32'h0, {31'h0, msel});
		apb(1'b0, `PPM_OFS_BUSCTL, 32'h0);
		chk("busctl_rst", {29'h0, `PPM_BUSCTL_RST}, rd);
		@(posedge sys_clk);
		mode_strap_pin <= 1'b1;
		ext(16'hffff, 16'h1234, 16'hffff, 16'h0f0f, 16'hffff, 16'ha5a5);
		chk("host_addr", 32'h1234, {16'h0, hp_a});
		chk("host_data", 32'ha5a5, {16'h0, hp_d});
		apb(1'b0, `PPM_OFS_PIO_IN, 32'h0);
		chk("pio_in", 32'h0f0f, rd);
		ext(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
		chk("dlo_hold_oe", 32'hffff, {16'h0, l_oe});
		chk("dlo_hold", 32'ha5a5, {16'h0, l_o});
		chk("addr_hold", 32'h1234, {16'h0, a_o});
		apb(1'b1, `PPM_OFS_BUSCTL, 32'h0);
		chk("addr_oe", 32'h0, {16'h0, a_oe});
		chk("dhi_oe", 32'h0, {16'h0, h_oe});
		chk("dlo_oe", 32'h0, {16'h0, l_oe});
		apb(1'b1, `PPM_OFS_PIO_OUT, 32'h5a5a);
		apb(1'b1, `PPM_OFS_PIO_DIR, 32'hffff);
		chk("pio_oe", 32'hffff, {16'h0, h_oe});
		chk("pio_out", 32'h5a5a, {16'h0, h_o});
		apb(1'b0, `PPM_OFS_PIO_DIR, 32'h0);
		chk("pio_dir", 32'hffff, rd);
		apb(1'b0, `PPM_OFS_STATUS, 32'h0);
		chk("status_host", 32'h1, rd);
		@(posedge sys_clk);
		rd_en <= 1'b1;
		rd_word <= 16'h3c5a;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("rd_oe", 32'hffff, {16'h0, l_oe});
		chk("rd_word", 32'h3c5a, {16'h0, l_o});
		@(posedge sys_clk);
		rd_en <= 1'b0;
		$display("Host mode test done");

		reset_dut(1'b1);
		chk("mem_sel", 32'h1, {31'h0, msel});
		chk("addr_oe", 32'hffff, {16'h0, a_oe});
		chk("addr_zero", 32'h0, {16'h0, a_o});
		apb(1'b1, `PPM_OFS_BUSCTL, 32'h0);
		chk("dhi_oe", 32'h0, {16'h0, h_oe});
		chk("dlo_oe", 32'h0, {16'h0, l_oe});
		apb(1'b1, `PPM_OFS_MEM_ADDR, 32'h0abc);
		chk("mem_addr", 32'h0abc, {16'h0, a_o});
		apb(1'b1, `PPM_OFS_MEM_DATA, 32'h1234_5678);
		chk("mem_data", 32'h1234_5678, {h_o, l_o});
		chk("mem_oe", 32'hffff_ffff, {h_oe, l_oe});
		apb(1'b1, `PPM_OFS_BUSCTL, 32'h7);
		apb(1'b0, `PPM_OFS_MEM_DATA, 32'h0);
		chk("mem_keep_oe", 32'hffff_ffff, {h_oe, l_oe});
		chk("mem_keep", 32'h1234_5678, {h_o, l_o});
		ext(16'h0, 16'h0, 16'hffff, 16'hcafe, 16'hffff, 16'hbeef);
		apb(1'b0, `PPM_OFS_MEM_DATA, 32'h0);
		chk("mem_rd", 32'hcafe_beef, rd);
		@(posedge sys_clk);
		mode_strap_pin <= 1'b0;
		apb(1'b0, `PPM_OFS_STATUS, 32'h0);
		chk("status_mem", 32'h2, rd);
		apb(1'b0, 12'h0fc, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, err});
		chk("unmapped_rd", 32'h0, rd);
		apb(1'b0, `PPM_OFS_BUSCTL, 32'h0);
		chk("busctl_wr", 32'h7, rd);
		$display("Memory mode test done");
		tally_and_finish();
	end
endmodule : ppm_strap_mux_tb
